// ---- core/pic_top.sv ----
// eight-level priority interrupt controller core with host strobes and cascade lines
// assumes all pins are already synchronous to clk_i; three-state pins resolved outside
`timescale 1ns/10ps
`include "pic_defines.svh"
module pic_top import pic_pkg::*; (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       cs_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic       cmd_select_line_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] data_o,
	output logic            data_oe_o,
	input  wire logic       ack_strobe_n_i,
	input  wire logic [7:0] request_inputs_i,
	output logic            int_o,
	input  wire logic [2:0] chain_id_lines_i,
	output logic      [2:0] chain_id_lines_o,
	output logic            chain_id_lines_oe_o,
	input  wire logic       master_select_buffer_enable_i,
	output logic            master_select_buffer_enable_o,
	output logic            master_select_buffer_enable_oe_o
);
	pic_state_t s, n;

	// fixed priority encoder: lowest index wins, bit 3 tells whether any bit is set
	function automatic logic [3:0] prio(input logic [7:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	logic [7:0] unm, rise, clr;
	logic [3:0] win, top;
	logic       pend, master, wr_go, rd_go, ack_fall, ack_rise, take, own, slave_hit;
	logic [1:0] last;

	// resolver: unmasked requests against the highest level in service
	assign unm  = s.request_latch & ~s.mask_latch;
	assign win  = prio(unm);
	assign top  = prio(s.in_service_latch);
	assign pend = win[3] && (!top[3] || win[2:0] < top[2:0]);
	// pin role only counts outside buffered operation
	assign master = s.sngl || (s.bufm ? s.msm : master_select_buffer_enable_i);
	assign wr_go  = !(wr_n_i || cs_n_i);
	assign rd_go  = !(rd_n_i || cs_n_i);
	assign ack_fall = s.ack_prev && !ack_strobe_n_i;
	assign ack_rise = !s.ack_prev && ack_strobe_n_i;
	assign last = s.fmt ? 2'h2 : 2'h3;
	assign slave_hit = !master && chain_id_lines_i == s.slave_reg[2:0];

	// per-level edge detect; prev resets high so a level already high at reset is no edge
	for (genvar g = 0; g < 8; g++) begin : g_edge
		assign rise[g] = request_inputs_i[g] && !s.req_prev[g];
	end

	// next state of the whole controller
	always_comb begin
		n    = s;
		take = 1'b0;
		clr  = 8'h00;
		own  = 1'b0;
		n.req_prev = request_inputs_i;
		n.wr_idle  = !wr_go;
		n.rd_idle  = !rd_go;
		n.ack_prev = ack_strobe_n_i;
		// acknowledge sequence: first pulse freezes the winner for the whole sequence
		if (ack_fall) begin
			n.ack_cnt = s.ack_cnt + 2'h1;
			if (s.ack_cnt == 2'h0) begin
				n.ack_fake = !win[3];
				n.ack_lvl  = win[3] ? win[2:0] : `PIC_DFLT_LVL;
				n.ack_casc = master && !s.sngl && win[3] && s.slave_reg[win[2:0]];
			end
			take = s.fmt ? (n.ack_cnt == 2'h2) : (n.ack_cnt == 2'h1);
		end
		// auto end of service releases the level when the last pulse ends
		if (ack_rise && s.ack_cnt == last) begin
			n.ack_cnt = 2'h0;
			if (s.auto_end_of_service) begin
				n.in_service_latch[s.ack_lvl] = 1'b0;
			end
		end
		// host writes, steered by the command select line
		if (wr_go && s.wr_idle) begin
			if (!cmd_select_line_i && data_i[`PIC_INIT_BIT]) begin
				n.ltim     = data_i[`PIC_LTIM_BIT];
				n.adi      = data_i[`PIC_ADI_BIT];
				n.sngl     = data_i[`PIC_SNGL_BIT];
				n.ic4      = data_i[`PIC_IC4_BIT];
				n.vec_lo   = data_i[7:5];
				n.mask_latch      = `PIC_MASK_RST;
				n.req_prev = `PIC_PREV_RST;                   // edge sense restarts
				n.request_latch      = 8'h00;
				n.read_isr = 1'b0;
				n.poll     = 1'b0;
				n.fmt      = 1'b0;
				n.auto_end_of_service     = 1'b0;
				n.bufm     = 1'b0;
				n.msm      = 1'b0;
				n.init     = PIC_WAIT_W2;
			end else if (cmd_select_line_i) begin
				case (s.init)
					PIC_WAIT_W2: begin
						n.vec_hi = data_i;
						n.init   = !s.sngl ? PIC_WAIT_W3 : (s.ic4 ? PIC_WAIT_W4 : PIC_READY);
					end
					PIC_WAIT_W3: begin
						n.slave_reg = data_i;
						n.init      = s.ic4 ? PIC_WAIT_W4 : PIC_READY;
					end
					PIC_WAIT_W4: begin
						n.fmt  = data_i[`PIC_FMT_BIT];
						n.auto_end_of_service = data_i[`PIC_AUTO_END_OF_SERVICE_BIT];
						n.msm  = data_i[`PIC_MS_BIT];
						n.bufm = data_i[`PIC_BUF_BIT];
						n.init = PIC_READY;
					end
					default: begin
						n.mask_latch = data_i;
					end
				endcase
			end else if (s.init == PIC_READY) begin
				if (data_i[`PIC_SEL_BIT]) begin
					n.poll = data_i[`PIC_POLL_BIT];
					if (data_i[`PIC_RR_BIT]) begin
						n.read_isr = data_i[`PIC_RIS_BIT];
					end
				end else if (data_i[`PIC_EOI_BIT]) begin
					if (data_i[`PIC_SPEC_BIT]) begin
						n.in_service_latch[data_i[2:0]] = 1'b0;
					end else if (top[3]) begin
						n.in_service_latch[top[2:0]] = 1'b0;               // clears the highest level served
					end
				end
			end
		end
		// in-service set comes after host commands: an end of service in the same
		// cycle must not wipe out a level that is being taken right now
		if (take) begin
			n.in_service_latch[n.ack_lvl] = 1'b1;
			if (!n.ack_fake) begin
				clr[n.ack_lvl] = 1'b1;
			end
		end
		// poll read acts as an acknowledge of the winning level
		if (rd_go && s.rd_idle && s.poll && cmd_select_line_i == 1'b0) begin
			n.poll = 1'b0;
			if (win[3]) begin
				n.in_service_latch[win[2:0]] = 1'b1;
				clr[win[2:0]]   = 1'b1;
			end
		end
		// request latch: a new rise beats a same-cycle clear so no event is lost
		n.request_latch = s.ltim ? request_inputs_i
			: (((n.request_latch & ~clr) | rise) & request_inputs_i);
		// data bus: acknowledge bytes first, then status reads
		n.doe  = 1'b0;
		n.dout = 8'h00;
		if (!ack_strobe_n_i && n.ack_cnt != 2'h0) begin
			own = master ? !n.ack_casc : slave_hit;
			if (s.fmt) begin
				if (n.ack_cnt == 2'h2) begin
					n.doe  = own;
					n.dout = {s.vec_hi[7:3], n.ack_lvl};
				end
			end else begin
				case (n.ack_cnt)
					2'h1: begin
						n.doe  = master;
						n.dout = `PIC_CALL_CODE;
					end
					2'h2: begin
						n.doe  = own;
						n.dout = s.adi ? {s.vec_lo, n.ack_lvl, 2'b00}
							: {s.vec_lo[2:1], n.ack_lvl, 3'b000};
					end
					default: begin
						n.doe  = own;
						n.dout = s.vec_hi;
					end
				endcase
			end
		end else if (rd_go) begin
			n.doe = 1'b1;
			if (!s.rd_idle) begin
				n.dout = s.dout;                              // byte held through the read
			end else if (cmd_select_line_i) begin
				n.dout = s.mask_latch;
			end else if (s.poll) begin
				n.dout = {win[3], 4'h0, win[2:0]};
			end else begin
				n.dout = s.read_isr ? s.in_service_latch : s.request_latch;
			end
		end
		// cascade lines: driven by a cascaded master, idle outside a cascaded sequence
		n.cas_oe = master && !s.sngl;
		n.cas    = (n.ack_cnt != 2'h0 && n.ack_casc) ? n.ack_lvl : 3'h0;
		// transceiver enable is active low while the data port drives
		n.msbe_oe = s.bufm;
		n.msbe    = s.bufm && !n.doe;
		n.intr    = pend;
	end

	// single state register; everything leaves the block from here
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s          <= '0;
			s.mask_latch      <= `PIC_MASK_RST;
			s.req_prev <= `PIC_PREV_RST;
			s.init     <= PIC_READY;
			s.wr_idle  <= 1'b1;
			s.rd_idle  <= 1'b1;
			s.ack_prev <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign data_o                           = s.dout;
	assign data_oe_o                        = s.doe;
	assign int_o                            = s.intr;
	assign chain_id_lines_o                 = s.cas;
	assign chain_id_lines_oe_o              = s.cas_oe;
	assign master_select_buffer_enable_o    = s.msbe;
	assign master_select_buffer_enable_oe_o = s.msbe_oe;

	// checks on the driven behaviour
	cs_blocks_bus_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(cs_n_i && ack_strobe_n_i) |=> !data_oe_o)
		else $error("data bus driven while deselected");
	read_drives_bus_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_go && ack_strobe_n_i) |=> data_oe_o)
		else $error("selected read did not drive the bus");
	call_code_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ack_fall && !s.fmt && s.ack_cnt == 2'h0 && master) |=>
		(data_oe_o && data_o == `PIC_CALL_CODE && s.in_service_latch[s.ack_lvl]))
		else $error("first call pulse wrong");
	ptr_first_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ack_fall && s.fmt && s.ack_cnt == 2'h0) |=> !data_oe_o)
		else $error("pointer first pulse drove the bus");
	ptr_sets_isr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ack_fall && s.fmt && s.ack_cnt == 2'h1) |=>
		(s.in_service_latch[s.ack_lvl] && data_o[2:0] == s.ack_lvl))
		else $error("pointer pulse did not set level");
	auto_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ack_rise && s.auto_end_of_service && s.ack_cnt == last) |=> !s.in_service_latch[$past(s.ack_lvl)])
		else $error("auto end did not clear level");
	default_seven_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ack_fall && s.ack_cnt == 2'h0 && !win[3]) |=>
		(s.ack_lvl == `PIC_DFLT_LVL && chain_id_lines_o == 3'h0))
		else $error("default level seven not taken");
	edge_sets_req_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!s.ltim && request_inputs_i[0] && !s.req_prev[0]) |=> s.request_latch[0])
		else $error("request rise lost");
	int_raise_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(unm != 8'h00 && s.in_service_latch == 8'h00) |=> int_o)
		else $error("pending request gave no interrupt");
	chain_master_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ack_fall && s.ack_cnt == 2'h0 && master && !s.sngl && win[3]
		&& s.slave_reg[win[2:0]]) |=> (chain_id_lines_o == s.ack_lvl && chain_id_lines_oe_o))
		else $error("master did not present slave id");

	// host port checks: deselected strobes leave the mask alone
	mask_kept_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cs_n_i |=> $stable(s.mask_latch))
		else $error("mask changed while deselected");
	// a selected write with command select high stores the mask once ready
	mask_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wr_go && s.wr_idle && cmd_select_line_i && s.init == PIC_READY) |=>
		s.mask_latch == $past(data_i))
		else $error("mask write not stored");
	// starting initialisation clears the mask
	init_clears_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wr_go && s.wr_idle && !cmd_select_line_i && data_i[`PIC_INIT_BIT]) |=>
		s.mask_latch == `PIC_MASK_RST)
		else $error("initialisation kept the mask");
	// status reads pick the latch that the last read command chose
	read_isr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_go && s.rd_idle && !cmd_select_line_i && !s.poll && s.read_isr
		&& ack_strobe_n_i) |=> data_o == $past(s.in_service_latch))
		else $error("in-service read wrong");
	read_irr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_go && s.rd_idle && !cmd_select_line_i && !s.poll && !s.read_isr
		&& ack_strobe_n_i) |=> data_o == $past(s.request_latch))
		else $error("request read wrong");
	read_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_go && s.rd_idle && cmd_select_line_i && ack_strobe_n_i) |=>
		data_o == $past(s.mask_latch))
		else $error("mask read wrong");
	// poll byte has its middle bits zero and is driven
	poll_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_go && s.rd_idle && s.poll && !cmd_select_line_i && ack_strobe_n_i) |=>
		(data_oe_o && data_o[6:3] == 4'h0))
		else $error("poll byte malformed");
	// with no strobe at all the port lets go of the bus
	bus_release_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!rd_go && ack_strobe_n_i) |=> !data_oe_o)
		else $error("bus driven with no strobe");
	// request inputs: level mode copies the pins, edge mode drops a fallen pin
	level_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s.ltim |=> s.request_latch == $past(request_inputs_i))
		else $error("level mode latch wrong");
	req_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!s.ltim && !request_inputs_i[0]) |=> !s.request_latch[0])
		else $error("request kept after pin fell");
	// nothing unmasked pending means no interrupt
	int_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!win[3] |=> !int_o)
		else $error("interrupt with nothing pending");
	// call format bytes two and three from a master that serves the level itself
	call_low_byte_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ack_fall && !s.fmt && s.ack_cnt == 2'h1 && master && !s.ack_casc && s.adi) |=>
		(data_oe_o && data_o == {s.vec_lo, s.ack_lvl, 2'h0}))
		else $error("call low byte wrong");
	high_byte_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ack_fall && !s.fmt && s.ack_cnt == 2'h2 && master && !s.ack_casc) |=>
		(data_oe_o && data_o == s.vec_hi))
		else $error("call high byte wrong");
	// pointer byte from a master that serves the level itself
	ptr_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ack_fall && s.fmt && s.ack_cnt == 2'h1 && master && !s.ack_casc) |=>
		(data_oe_o && data_o == {s.vec_hi[7:3], s.ack_lvl}))
		else $error("pointer byte wrong");
	// chain id lines stay idle outside a sequence and undriven when single
	cas_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(s.ack_cnt == 2'h0 && !ack_fall) |=> chain_id_lines_o == 3'h0)
		else $error("chain id active outside sequence");
	chain_single_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s.sngl |=> !chain_id_lines_oe_o)
		else $error("single device drove chain id");
	// buffered operation turns the role pin into the transceiver enable
	buf_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s.bufm |=> master_select_buffer_enable_oe_o)
		else $error("buffer enable not driven");
	buf_enable_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(master_select_buffer_enable_oe_o && data_oe_o) |-> !master_select_buffer_enable_o)
		else $error("buffer enable high while driving");
endmodule

// ---- inc/pic_defines.svh ----
// constants of the priority interrupt controller: command word fields, codes, reset values
// assumes the includer works on 8-bit host data and 3-bit level numbers
//
// How it works
// - keep request latch and in-service latch
// - resolver picks highest request, sets in-service bit
// - mask gates requests, lower levels unaffected
// - chip select high ignores read and write
// - selected write strobe stores command words
// - selected read drives latch or poll level
// - command select picks register with strobes
// - data port is three-state eight bits
// - master drives chain id of slave
// - matching slave drives routine address bytes
// - raised request input sets request bit
// - unmasked pending request raises interrupt output
// - call format pulse one sets, sends CD
// - call format sends low then high byte
// - call format auto end clears after third
// - pointer format first pulse leaves bus undriven
// - pointer format second pulse sets, sends pointer
// - pointer format auto end clears after second
// - no request pending means answer level seven
// - default level seven keeps chain id idle
// - edge mode needs rise, level mode level
// - master select pin input, buffered drives enable
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH
`define PIC_INIT_BIT   4
`define PIC_SEL_BIT    3
`define PIC_LTIM_BIT   3
`define PIC_ADI_BIT    2
`define PIC_SNGL_BIT   1
`define PIC_IC4_BIT    0
`define PIC_FMT_BIT    0
`define PIC_AUTO_END_OF_SERVICE_BIT   1
`define PIC_MS_BIT     2
`define PIC_BUF_BIT    3
`define PIC_EOI_BIT    5
`define PIC_SPEC_BIT   6
`define PIC_POLL_BIT   2
`define PIC_RR_BIT     1
`define PIC_RIS_BIT    0
`define PIC_CALL_CODE  8'hCD
`define PIC_DFLT_LVL   3'h7
`define PIC_MASK_RST   8'h00
`define PIC_PREV_RST   8'hFF
`endif

// ---- inc/pic_pkg.sv ----
// types of the priority interrupt controller
// assumes the defines header is not needed here: types only
package pic_pkg;
	typedef enum logic [1:0] {PIC_WAIT_W2, PIC_WAIT_W3, PIC_WAIT_W4, PIC_READY} pic_init_t;
	typedef struct packed {
		logic [7:0] request_latch;
		logic [7:0] in_service_latch;
		logic [7:0] mask_latch;
		logic [7:0] req_prev;
		logic       ltim, adi, sngl, ic4, fmt, auto_end_of_service, bufm, msm;
		logic [2:0] vec_lo;
		logic [7:0] vec_hi;
		logic [7:0] slave_reg;
		pic_init_t  init;
		logic       read_isr, poll, wr_idle, rd_idle, ack_prev;
		logic [1:0] ack_cnt;
		logic [2:0] ack_lvl;
		logic       ack_casc, ack_fake, intr;
		logic [7:0] dout;
		logic       doe;
		logic [2:0] cas;
		logic       cas_oe, msbe, msbe_oe;
	} pic_state_t;
endpackage

// ---- bench/pic_cpu_model.sv ----
// host cpu model: sends trains of acknowledge pulses and keeps the bytes it saw
// assumes the device answers one cycle after it sees a pulse start
`timescale 1ns/10ps
module pic_cpu_model (
	input  wire logic        clk_i,
	input  wire logic        start_i,
	input  wire logic [1:0]  n_pulses_i,
	input  wire logic [7:0]  data_i,
	input  wire logic        data_oe_i,
	output logic             ack_strobe_n_o,
	output logic      [23:0] bytes_o,
	output logic      [2:0]  oe_seen_o,
	output logic             done_o
);
	int i;
	// idle levels before the first train
	initial begin
		ack_strobe_n_o = 1'b1;
		bytes_o = 24'h000000;
		oe_seen_o = 3'h0;
		done_o = 1'b0;
	end
	// three cycles low and three high, so a registered answer has settled when captured
	always begin
		@(posedge clk_i);
		if (start_i) begin
			done_o <= 1'b0;
			for (i = 0; i < n_pulses_i; i++) begin
				ack_strobe_n_o <= 1'b0;
				repeat (3) @(posedge clk_i);
				bytes_o[i*8+:8] <= data_i;
				oe_seen_o[i] <= data_oe_i;
				ack_strobe_n_o <= 1'b1;
				repeat (3) @(posedge clk_i);
			end
			done_o <= 1'b1;
		end
	end
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the interrupt controller: host accesses and ack trains
// assumes chain id input idle and the pin strapped as master
`timescale 1ns/10ps
module tb;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        cs_n = 1'b1;
	logic        rd_n = 1'b1;
	logic        wr_n = 1'b1;
	logic        cmd = 1'b0;
	logic [7:0]  din = 8'h00;
	logic [7:0]  reqs = 8'h00;
	logic        start = 1'b0;
	logic [1:0]  npul = 2'h0;
	logic [7:0]  data_o;
	logic        data_oe_o;
	logic        ack_n;
	logic        int_o;
	logic [2:0]  cid_o;
	logic        cid_oe;
	logic        msbe;
	logic        msbe_oe;
	logic [23:0] bytes;
	logic [2:0]  oes;
	logic        done;
	int          n_mismatch = 0;
	int          n_checks = 0;
	// 100 MHz clock
	always #5 clk_i = ~clk_i;
	pic_top dut_u (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.cmd_select_line_i(cmd), .data_i(din), .data_o(data_o), .data_oe_o(data_oe_o),
		.ack_strobe_n_i(ack_n), .request_inputs_i(reqs), .int_o(int_o),
		.chain_id_lines_i(3'h0), .chain_id_lines_o(cid_o), .chain_id_lines_oe_o(cid_oe),
		.master_select_buffer_enable_i(1'b1), .master_select_buffer_enable_o(msbe),
		.master_select_buffer_enable_oe_o(msbe_oe)
	);
	pic_cpu_model cpu_u (
		.clk_i(clk_i), .start_i(start), .n_pulses_i(npul), .data_i(data_o),
		.data_oe_i(data_oe_o), .ack_strobe_n_o(ack_n), .bytes_o(bytes), .oe_seen_o(oes),
		.done_o(done)
	);
	// byte compare; bits are zero-extended by the caller
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// host write: one edge low, then an idle edge so the next write is a new one
	task automatic wr(input logic sel_n, input logic a, input logic [7:0] d);
		@(posedge clk_i);
		cs_n <= sel_n;
		wr_n <= 1'b0;
		cmd <= a;
		din <= d;
		@(posedge clk_i);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		@(posedge clk_i);
	endtask
	// host read: output is registered, so it is looked at two edges after the strobe
	task automatic rd(input logic sel_n, input logic a, input logic [7:0] exp, input string s);
		@(posedge clk_i);
		cs_n <= sel_n;
		rd_n <= 1'b0;
		cmd <= a;
		repeat (2) @(posedge clk_i);
		#1;
		chk(s, sel_n ? 8'h00 : exp, data_o);
		chk({s, " oe"}, {7'h0, ~sel_n}, {7'h0, data_oe_o});
		@(posedge clk_i);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask
	// one ack train; the done flag of the previous train is let settle first
	task automatic ack(input logic [1:0] n);
		int k;
		@(posedge clk_i);
		npul <= n;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		@(posedge clk_i);
		for (k = 0; k < 100 && done !== 1'b1; k++)
			@(posedge clk_i);
		if (done !== 1'b1) begin
			n_mismatch++;
			print_verdict();
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// call format, single, interval 4, auto end; level 0 masked
		wr(0, 0, 8'hB7);
		wr(0, 1, 8'h48);
		wr(0, 1, 8'h02);
		wr(0, 1, 8'h01);
		reqs <= 8'h05;
		repeat (3) @(posedge clk_i);
		chk("int", 8'h01, {7'h0, int_o});
		wr(0, 0, 8'h0A);
		rd(0, 0, 8'h05, "request latch");
		rd(0, 1, 8'h01, "mask latch");
		ack(3);
		chk("call code", 8'hCD, bytes[7:0]);
		chk("low byte", 8'hA8, bytes[15:8]);
		chk("high byte", 8'h48, bytes[23:16]);
		chk("bus driven", 8'h07, {5'h0, oes});
		chk("int masked", 8'h00, {7'h0, int_o});
		rd(0, 0, 8'h01, "request after ack");
		wr(0, 0, 8'h0B);
		rd(0, 0, 8'h00, "auto end");
		// deselected strobes change nothing and never drive the bus
		wr(1, 1, 8'hFF);
		rd(1, 1, 8'h00, "deselected read");
		rd(0, 1, 8'h01, "mask kept");
		// pointer format, interval 8, no auto end; level 4 rises
		wr(0, 0, 8'h13);
		wr(0, 1, 8'h48);
		wr(0, 1, 8'h01);
		reqs <= 8'h10;
		repeat (3) @(posedge clk_i);
		ack(2);
		chk("first pulse oe", 8'h00, {7'h0, oes[0]});
		chk("pointer", 8'h4C, bytes[15:8]);
		wr(0, 0, 8'h0B);
		rd(0, 0, 8'h10, "in service kept");
		wr(0, 0, 8'h20);
		rd(0, 0, 8'h00, "after end of service");
		// nothing pending at the pulses: level 7 answers, chain id stays idle
		ack(2);
		chk("default pointer", 8'h4F, bytes[15:8]);
		chk("chain id idle", 8'h00, {5'h0, cid_o});
		rd(0, 0, 8'h80, "default in service");
		// level mode, buffered, interval 8; a poll read acknowledges level 4
		wr(0, 0, 8'h1B);
		wr(0, 1, 8'h48);
		wr(0, 1, 8'h0C);
		#1;
		chk("buffer enable oe", 8'h01, {7'h0, msbe_oe});
		chk("buffer enable idle", 8'h01, {7'h0, msbe});
		chk("chain id oe", 8'h00, {7'h0, cid_oe});
		wr(0, 0, 8'h0C);
		rd(0, 0, 8'h84, "poll byte");
		chk("int nested", 8'h00, {7'h0, int_o});
		wr(0, 0, 8'h20);
		ack(3);
		chk("interval 8 byte", 8'h20, bytes[15:8]);
		chk("interval 8 driven", 8'h07, {5'h0, oes});
		print_verdict();
	end
endmodule
